// ---- hw/qls_params.svh ----
// constants for the load switch bus controller: device addresses, register map, field layout, timing
// assumes a 20 MHz system clock and a standard-mode two-wire bus
`ifndef QLS_PARAMS_SVH
`define QLS_PARAMS_SVH

`define QLS_CLK_PERIOD_NS      50
`define QLS_SCL_PERIOD_NS      10000
`define QLS_QUARTER_CYC        ((`QLS_SCL_PERIOD_NS / 4) / `QLS_CLK_PERIOD_NS)

`define QLS_ADDR_BASE          8'hE0
`define QLS_ADDR_BCAST         8'hEE
`define QLS_STRAP_INVALID      3'h7
`define QLS_RW_READ            1'b1
`define QLS_RW_WRITE           1'b0

`define QLS_SUB_AUTOINC_BIT    7
`define QLS_REG_CFG_FIRST      7'h01
`define QLS_REG_CFG_LAST       7'h04
`define QLS_REG_CTRL           7'h05
`define QLS_REG_MODE_FIRST     7'h06
`define QLS_REG_MODE_LAST      7'h11

`define QLS_SLEW_LSB           0
`define QLS_SLEW_MAX_VALID     3'h4
`define QLS_SLEW_RESET         3'h3
`define QLS_DRAIN_LSB          4
`define QLS_DRAIN_RESET        2'h2
`define QLS_DELAY_LSB          6
`define QLS_DELAY_RESET        2'h0
`define QLS_CTRL_RESET         8'h00

`endif

// ---- hw/qls_pkg.sv ----
// types shared by the load switch bus controller and its line engine
// constants live in qls_params.svh
package qls_pkg;

  typedef enum logic [1:0] {
    KIND_WRITE     = 2'h0,
    KIND_READ      = 2'h1,
    KIND_BROADCAST = 2'h2
  } cmd_kind_t;

  typedef struct packed {
    cmd_kind_t   kind;
    logic [2:0]  strap;
    logic [6:0]  reg_addr;
    logic        auto_inc;
    logic [4:0]  count;
  } cmd_t;

  typedef struct packed {
    logic err;
    logic nack;
  } rsp_t;

  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_BIT   = 2'h1,
    OP_STOP  = 2'h2
  } bus_op_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_TX    = 3'h3,
    ST_WAITD = 3'h2,
    ST_RX    = 3'h6,
    ST_STOP  = 3'h7
  } ctrl_state_t;

  typedef enum logic [2:0] {
    ROLE_DEVW  = 3'h0,
    ROLE_SUB   = 3'h1,
    ROLE_WDATA = 3'h2,
    ROLE_DEVR  = 3'h3,
    ROLE_RDATA = 3'h4,
    ROLE_MODE  = 3'h5
  } byte_role_t;

endpackage

// ---- hw/i2c_line_engine.sv ----
// line engine: one start, stop or single bit on open-drain clock and data lines
// assumes pull-ups on both lines; the far end may stretch the clock low
`timescale 1ns/1ps
`include "qls_params.svh"

module i2c_line_engine
  import qls_pkg::*;
#(
  parameter int QUARTER = `QLS_QUARTER_CYC
) (
  input  wire logic    clock,
  input  wire logic    rst,
  input  wire logic    op_valid,
  output logic         op_ready,
  input  wire bus_op_t op,
  input  wire logic    bit_in,
  output logic         done,
  output logic         bit_out,
  input  wire logic    scl_in,
  output logic         scl_out,
  output logic         scl_oe_n,
  input  wire logic    sda_in,
  output logic         sda_out,
  output logic         sda_oe_n
);

  logic        busy_reg,   busy_next;
  logic [1:0]  phase_reg,  phase_next;
  logic [15:0] div_reg,    div_next;
  bus_op_t     op_reg,     op_next;
  logic        bit_reg,    bit_next;
  logic        pull_scl_reg, pull_scl_next;
  logic        pull_sda_reg, pull_sda_next;
  logic        sample_reg, sample_next;
  logic        done_reg,   done_next;
  logic        scl_m, scl_s, sda_m, sda_s;
  logic        tick;

  // quarter-bit tick; held while the clock line is released but still low
  assign tick     = busy_reg && (div_reg == 16'(QUARTER - 1)) && !(!pull_scl_reg && !scl_s);
  assign op_ready = !busy_reg;
  assign done     = done_reg;
  assign bit_out  = sample_reg;
  assign scl_out  = 1'b0;
  assign sda_out  = 1'b0;
  assign scl_oe_n = !pull_scl_reg;
  assign sda_oe_n = !pull_sda_reg;

  always_comb begin
    busy_next     = busy_reg;
    phase_next    = phase_reg;
    div_next      = div_reg;
    op_next       = op_reg;
    bit_next      = bit_reg;
    pull_scl_next = pull_scl_reg;
    pull_sda_next = pull_sda_reg;
    sample_next   = sample_reg;
    done_next     = 1'b0;
    if (!busy_reg) begin
      if (op_valid) begin
        busy_next  = 1'b1;
        phase_next = 2'h0;
        div_next   = 16'h0000;
        op_next    = op;
        bit_next   = bit_in;
        unique case (op)
          OP_START: pull_sda_next = 1'b0;
          OP_BIT:   pull_sda_next = !bit_in;
          default:  pull_sda_next = 1'b1;
        endcase
      end
    end else if (tick) begin
      div_next = 16'h0000;
      if (phase_reg == 2'h3) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        phase_next = phase_reg + 2'h1;
        unique case (phase_reg)
          2'h0: pull_scl_next = 1'b0;
          2'h1: begin
            if (op_reg == OP_START) begin
              pull_sda_next = 1'b1;
            end else if (op_reg == OP_STOP) begin
              pull_sda_next = 1'b0;
            end else begin
              sample_next = sda_s;
            end
          end
          default: begin
            if (op_reg != OP_STOP) begin
              pull_scl_next = 1'b1;
            end
          end
        endcase
      end
    end else begin
      div_next = (div_reg == 16'(QUARTER - 1)) ? div_reg : div_reg + 16'h0001;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_reg     <= 1'b0;
      phase_reg    <= 2'h0;
      div_reg      <= 16'h0000;
      op_reg       <= OP_START;
      bit_reg      <= 1'b1;
      pull_scl_reg <= 1'b0;
      pull_sda_reg <= 1'b0;
      sample_reg   <= 1'b1;
      done_reg     <= 1'b0;
      scl_m        <= 1'b1;
      scl_s        <= 1'b1;
      sda_m        <= 1'b1;
      sda_s        <= 1'b1;
    end else begin
      busy_reg     <= busy_next;
      phase_reg    <= phase_next;
      div_reg      <= div_next;
      op_reg       <= op_next;
      bit_reg      <= bit_next;
      pull_scl_reg <= pull_scl_next;
      pull_sda_reg <= pull_sda_next;
      sample_reg   <= sample_next;
      done_reg     <= done_next;
      scl_m        <= scl_in;
      scl_s        <= scl_m;
      sda_m        <= sda_in;
      sda_s        <= sda_m;
    end
  end

endmodule

// ---- hw/quad_load_switch_i2c_ctrl.sv ----
// bus controller that programs a four-channel load switch over its two-wire port
// assumes one user issuing whole commands; the line engine owns the pins
`timescale 1ns/1ps
`include "qls_params.svh"

// Behaviour
// (R1) slew codes 000..100 are the valid ones
// (R2) never send slew codes 101, 110, 111
// (R3) drain field: 2 bits, reset 10
// (R4) mode registers hold per-channel on/off states
// (R5) broadcast address EEh reaches all devices
// (R6) broadcast copies mode bits 3:0 into control
// (R7) broadcast: start, EEh, mode address, stop
// (R8) other commands send sub-address with auto-increment
// (R9) every data transfer is a full byte
// (R10) auto-increment advances pointer after each byte
// (R11) direction bit: 0 write, 1 read
// (R12) start and stop framing every command
// (R13) receiver acknowledges each byte; the controller answers the last read byte with a not-acknowledge
// (R14) single write is 29 clock cycles
// (R15) burst write is 20 plus 9 per byte
// (R16) writes end with stop, one block each
// (R17) read preceded by sub-address write, repeated start
// (R18) single read is 39 clock cycles
// (R19) burst read is 30 plus 9 per byte
// (R20) reads end with stop, one block each
// (R21) on-delay field: 2 bits, reset 00
// (R22) straps pick E0h..ECh; EEh invalid as unique
// (R23) control register 05h: mode bits, enables
// (R24) modes 06h..11h, configurations 01h..04h
// (R25) device acknowledges both broadcast bytes, copies at stop
module quad_load_switch_i2c_ctrl
  import qls_pkg::*;
#(
  parameter int QUARTER = `QLS_QUARTER_CYC
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire cmd_t       cmd,
  input  wire logic       wdata_valid,
  output logic            wdata_ready,
  input  wire logic [7:0] wdata,
  output logic            rdata_valid,
  output logic [7:0]      rdata,
  output logic            done,
  output rsp_t            rsp,
  output logic            busy,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe_n,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n
);

  ctrl_state_t state_reg,  state_next;
  byte_role_t  role_reg,   role_next;
  cmd_t        cmd_reg,    cmd_next;
  logic [7:0]  shift_reg,  shift_next;
  logic [3:0]  bcnt_reg,   bcnt_next;
  logic [4:0]  remain_reg, remain_next;
  logic [6:0]  ptr_reg,    ptr_next;
  rsp_t        rsp_reg,    rsp_next;
  logic [7:0]  rdata_reg,  rdata_next;
  logic        rvalid_reg, rvalid_next;
  logic        done_reg,   done_next;
  logic        op_valid, op_ready, eng_done, eng_bit, bit_in;
  bus_op_t     op;

  function automatic logic [7:0] dev_byte(input logic [2:0] strap, input logic rw);
    dev_byte = `QLS_ADDR_BASE | {4'h0, strap, 1'b0} | {7'h00, rw}; // [R22] [R11]
  endfunction

  function automatic logic cmd_ok(input cmd_t c);
    logic ok;
    ok = (c.count != 5'h00);
    if (c.kind == KIND_BROADCAST) begin
      ok = (c.reg_addr >= `QLS_REG_MODE_FIRST) && (c.reg_addr <= `QLS_REG_MODE_LAST); // [R24] [R7]
    end else if (c.kind != KIND_WRITE && c.kind != KIND_READ) begin
      ok = 1'b0;
    end else if (c.strap == `QLS_STRAP_INVALID) begin
      ok = 1'b0; // [R22]
    end
    cmd_ok = ok;
  endfunction

  function automatic logic slew_bad(input logic [6:0] ptr, input logic [7:0] b);
    slew_bad = (ptr >= `QLS_REG_CFG_FIRST) && (ptr <= `QLS_REG_CFG_LAST)
               && (b[`QLS_SLEW_LSB +: 3] > `QLS_SLEW_MAX_VALID); // [R1] [R2]
  endfunction

  i2c_line_engine #(
    .QUARTER (QUARTER)
  ) u_line (
    .clock    (clock),
    .rst      (rst),
    .op_valid (op_valid),
    .op_ready (op_ready),
    .op       (op),
    .bit_in   (bit_in),
    .done     (eng_done),
    .bit_out  (eng_bit),
    .scl_in   (scl_in),
    .scl_out  (scl_out),
    .scl_oe_n (scl_oe_n),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe_n (sda_oe_n)
  );

  assign cmd_ready   = (state_reg == ST_IDLE);
  assign wdata_ready = (state_reg == ST_WAITD);
  assign busy        = (state_reg != ST_IDLE);
  assign rdata_valid = rvalid_reg;
  assign rdata       = rdata_reg;
  assign done        = done_reg;
  assign rsp         = rsp_reg;

  // one line operation per bus state; a byte is 8 data bit slots plus an acknowledge slot
  always_comb begin
    op_valid = 1'b0;
    op       = OP_BIT;
    bit_in   = 1'b1;
    unique case (state_reg)
      ST_START: begin
        op_valid = 1'b1;
        op       = OP_START; // [R12] [R17]
      end
      ST_TX: begin
        op_valid = 1'b1;
        bit_in   = (bcnt_reg < 4'h8) ? shift_reg[7] : 1'b1; // [R9] [R13]
      end
      ST_RX: begin
        op_valid = 1'b1;
        // last byte read is answered with a not-acknowledge so the device lets go of the data line
        bit_in   = (bcnt_reg < 4'h8) ? 1'b1 : (remain_reg == 5'h01); // [R13]
      end
      ST_STOP: begin
        op_valid = 1'b1;
        op       = OP_STOP; // [R12] [R16] [R20]
      end
      default: op_valid = 1'b0;
    endcase
    // the engine is idle again while its done pulse shows; a request then would repeat the old bit
    if (eng_done) begin
      op_valid = 1'b0;
    end
  end

  always_comb begin
    state_next  = state_reg;
    role_next   = role_reg;
    cmd_next    = cmd_reg;
    shift_next  = shift_reg;
    bcnt_next   = bcnt_reg;
    remain_next = remain_reg;
    ptr_next    = ptr_reg;
    rsp_next    = rsp_reg;
    rdata_next  = rdata_reg;
    rvalid_next = 1'b0;
    done_next   = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (cmd_valid) begin
          if (cmd_ok(cmd)) begin
            cmd_next    = cmd;
            remain_next = cmd.count;
            ptr_next    = cmd.reg_addr;
            role_next   = ROLE_DEVW;
            rsp_next    = '0;
            state_next  = ST_START;
          end else begin
            rsp_next  = '{err: 1'b1, nack: 1'b0};
            done_next = 1'b1;
          end
        end
      end
      ST_START: begin
        if (eng_done) begin
          bcnt_next  = 4'h0;
          state_next = ST_TX;
          if (role_reg == ROLE_DEVR) begin
            shift_next = dev_byte(cmd_reg.strap, `QLS_RW_READ); // [R17]
          end else if (cmd_reg.kind == KIND_BROADCAST) begin
            shift_next = `QLS_ADDR_BCAST; // [R5] [R7]
          end else begin
            shift_next = dev_byte(cmd_reg.strap, `QLS_RW_WRITE);
          end
        end
      end
      ST_TX: begin
        if (eng_done) begin
          if (bcnt_reg < 4'h8) begin
            shift_next = {shift_reg[6:0], 1'b0};
            bcnt_next  = bcnt_reg + 4'h1;
          end else if (eng_bit) begin
            rsp_next   = '{err: 1'b1, nack: 1'b1};
            state_next = ST_STOP;
          end else begin
            bcnt_next = 4'h0;
            unique case (role_reg)
              ROLE_DEVW: begin
                if (cmd_reg.kind == KIND_BROADCAST) begin
                  role_next  = ROLE_MODE;
                  shift_next = {1'b0, cmd_reg.reg_addr}; // [R7] [R4] [R6]
                end else begin
                  role_next  = ROLE_SUB;
                  shift_next = {cmd_reg.auto_inc, cmd_reg.reg_addr}; // [R8] [R10]
                end
              end
              ROLE_SUB: begin
                if (cmd_reg.kind == KIND_READ) begin
                  role_next  = ROLE_DEVR;
                  state_next = ST_START; // [R17] [R18] [R19]
                end else begin
                  role_next  = ROLE_WDATA;
                  state_next = ST_WAITD;
                end
              end
              ROLE_WDATA: begin
                remain_next = remain_reg - 5'h01;
                ptr_next    = cmd_reg.auto_inc ? ptr_reg + 7'h01 : ptr_reg; // [R10]
                state_next  = (remain_reg == 5'h01) ? ST_STOP : ST_WAITD; // [R14] [R15]
              end
              ROLE_DEVR: begin
                role_next  = ROLE_RDATA;
                state_next = ST_RX;
              end
              default: state_next = ST_STOP; // [R7]
            endcase
          end
        end
      end
      ST_WAITD: begin
        if (wdata_valid) begin
          if (slew_bad(ptr_reg, wdata)) begin
            rsp_next   = '{err: 1'b1, nack: 1'b0}; // [R2]
            state_next = ST_STOP;
          end else begin
            shift_next = wdata; // [R9]
            bcnt_next  = 4'h0;
            state_next = ST_TX;
          end
        end
      end
      ST_RX: begin
        if (eng_done) begin
          if (bcnt_reg < 4'h8) begin
            shift_next = {shift_reg[6:0], eng_bit};
            bcnt_next  = bcnt_reg + 4'h1;
          end else begin
            rdata_next  = shift_reg; // [R9]
            rvalid_next = 1'b1;
            bcnt_next   = 4'h0;
            remain_next = remain_reg - 5'h01;
            ptr_next    = cmd_reg.auto_inc ? ptr_reg + 7'h01 : ptr_reg; // [R10]
            state_next  = (remain_reg == 5'h01) ? ST_STOP : ST_RX; // [R18] [R19]
          end
        end
      end
      ST_STOP: begin
        if (eng_done) begin
          done_next  = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg  <= ST_IDLE;
      role_reg   <= ROLE_DEVW;
      cmd_reg    <= '0;
      shift_reg  <= 8'h00;
      bcnt_reg   <= 4'h0;
      remain_reg <= 5'h00;
      ptr_reg    <= 7'h00;
      rsp_reg    <= '0;
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
      done_reg   <= 1'b0;
    end else begin
      state_reg  <= state_next;
      role_reg   <= role_next;
      cmd_reg    <= cmd_next;
      shift_reg  <= shift_next;
      bcnt_reg   <= bcnt_next;
      remain_reg <= remain_next;
      ptr_reg    <= ptr_next;
      rsp_reg    <= rsp_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
      done_reg   <= done_next;
    end
  end

endmodule

// ---- verif/qls_device_model.sv ----
// behavioural four-channel load switch target on the two-wire bus
// assumes the bench resolves both open-drain lines and feeds them back
`timescale 1ns/1ps
module qls_device_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [2:0] strap,
  output logic            sda_low
);
  logic [7:0] regs [0:31];
  logic [7:0] shreg;
  logic [6:0] ptr, mode_sel;
  logic       rd, sel, bcast, ainc, tx, pend, in_frame, bad_slew;
  int         bitn, nbyte, pulses, last_frame;

  initial begin
    for (int i = 0; i < 32; i++) regs[i] = 8'h00;
    for (int i = 1; i < 5; i++) regs[i] = 8'h23;
    {sda_low, in_frame, pend, tx, sel, bad_slew} = '0;
    bitn = 0;
    nbyte = 0;
  end

  // start or repeated start
  always @(negedge sda) if (scl === 1'b1) begin
    if (!in_frame) pulses = 0;
    in_frame = 1;
    bitn = 0;
    nbyte = 0;
    sel = 0;
    tx = 0;
    pend = 0;
  end

  // stop: the broadcast copy lands here
  always @(posedge sda) if (scl === 1'b1 && in_frame) begin
    if (pend) regs[5][3:0] = regs[mode_sel][3:0];
    pend = 0;
    in_frame = 0;
    last_frame = pulses + 1;
  end

  always @(posedge scl) begin
    pulses = pulses + 1;
    if (bitn == 8) begin
      bitn = 0;
      if (tx) begin
        if (ainc) ptr = ptr + 7'h01;
        if (sda) tx = 0;
      end else if (sel && rd && nbyte == 1) tx = 1;
    end else begin
      shreg = {shreg[6:0], sda};
      bitn = bitn + 1;
      if (bitn == 8 && !tx) begin
        if (nbyte == 0) begin
          rd = shreg[0];
          bcast = shreg == 8'hEE;
          sel = bcast || (shreg[7:1] == {4'hE, strap} && strap != 3'h7);
        end else if (sel && bcast) begin
          mode_sel = shreg[6:0];
          pend = 1;
        end else if (sel && nbyte == 1) begin
          ptr = shreg[6:0];
          ainc = shreg[7];
        end else if (sel) begin
          if (ptr >= 7'h01 && ptr <= 7'h04 && shreg[2:0] > 3'h4) bad_slew = 1;
          regs[ptr] = shreg;
          if (ainc) ptr = ptr + 7'h01;
        end
        nbyte = nbyte + 1;
      end
    end
  end

  always @(negedge scl) begin
    if (bitn == 8 && !tx) sda_low = sel;
    else if (tx && bitn < 8) sda_low = !regs[ptr][7 - bitn];
    else sda_low = 0;
  end
endmodule

// ---- verif/qls_checker.sv ----
// assertions on the load switch bus controller's ports
// bound into every instance of the controller
`timescale 1ns/1ps
module qls_checker
  import qls_pkg::*;
#(
  parameter int QUARTER = 50
) (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire cmd_t       cmd,
  input wire logic       wdata_ready,
  input wire logic       rdata_valid,
  input wire logic [7:0] rdata,
  input wire logic       done,
  input wire rsp_t       rsp,
  input wire logic       busy,
  input wire logic       scl_oe_n,
  input wire logic       sda_oe_n
);
  localparam int LIM = 16 * QUARTER;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic take, bad;
  assign take = cmd_valid && cmd_ready;
  assign bad = (cmd.kind == KIND_BROADCAST) ? (cmd.reg_addr < 7'h06 || cmd.reg_addr > 7'h11)
                                            : (cmd.count == 5'h00 || cmd.strap == 3'h7 || cmd.kind == 2'h3);
  sequence s_start;
    scl_oe_n && $fell(sda_oe_n);
  endsequence
  sequence s_stop;
    $past(scl_oe_n) && scl_oe_n && $rose(sda_oe_n);
  endsequence
  a_start_opens: assert property (take && !bad |-> ##[1:LIM] s_start)
    else $error("command began without a start");
  a_stop_done: assert property (s_stop |-> ##[0:LIM] done)
    else $error("stop not followed by done");
  a_refuse_quiet: assert property (take && bad |=> done && rsp.err && $stable(sda_oe_n))
    else $error("bad command not refused at once");
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_ready_idle: assert property (cmd_ready != busy)
    else $error("ready and busy disagree");
  a_idle_released: assert property ($fell(busy) |-> done && scl_oe_n && sda_oe_n)
    else $error("command ended without a stop on released lines");
  a_wready_busy: assert property (wdata_ready |-> busy)
    else $error("write data asked while idle");
  a_rdata_hold: assert property (!rdata_valid |-> $stable(rdata))
    else $error("read data moved without a pulse");
  a_rsp_hold: assert property (!busy && !done |-> $stable(rsp))
    else $error("response moved outside done");
endmodule

bind quad_load_switch_i2c_ctrl qls_checker #(.QUARTER(QUARTER)) i_chk (
  .clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
  .wdata_ready(wdata_ready), .rdata_valid(rdata_valid), .rdata(rdata), .done(done),
  .rsp(rsp), .busy(busy), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n)
);

// ---- verif/quad_load_switch_i2c_ctrl_tb.sv ----
// bench for the load switch bus controller against a behavioural device
// resolves the open-drain clock line from the controller and the data line from the controller and the device
`timescale 1ns/1ps
module quad_load_switch_i2c_ctrl_tb
  import qls_pkg::*;
;
  localparam int Q = 4;
  logic       clock, rst, cmd_valid, cmd_ready, wdata_valid, wdata_ready, rdata_valid;
  logic       done, busy, scl_out, sda_out, scl_oe_n, sda_oe_n, dev_low;
  logic [7:0] wdata, rdata;
  logic [7:0] wbuf [0:3];
  logic [7:0] rbuf [0:7];
  cmd_t       cmd;
  rsp_t       rsp;
  int         miscompares, compares, cycles, rcnt;
  wire        scl = scl_oe_n;
  wire        sda = sda_oe_n & !dev_low;

  quad_load_switch_i2c_ctrl #(.QUARTER(Q)) i_dut (
    .clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .wdata_valid(wdata_valid), .wdata_ready(wdata_ready), .wdata(wdata), .rdata_valid(rdata_valid),
    .rdata(rdata), .done(done), .rsp(rsp), .busy(busy), .scl_in(scl), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n)
  );
  qls_device_model i_dev (.scl(scl), .sda(sda), .strap(3'h5), .sda_low(dev_low));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic final_report;
    if (miscompares == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      $display("unexpected at %0t: run timed out", $time);
      final_report();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // one whole command; fr is the expected bus cycle count, 0 to skip
  task automatic do_cmd(input cmd_kind_t k, input logic [6:0] a, input logic ai, input logic [4:0] n,
                        input logic [1:0] er, input int fr, input logic [2:0] s = 3'h5);
    int   i;
    logic got_done;
    i = 0;
    got_done = 1'b0;
    rcnt = 0;
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd <= '{kind: k, strap: s, reg_addr: a, auto_inc: ai, count: n};
    @(negedge clock);
    while (cmd_ready !== 1'b1) @(negedge clock);
    @(posedge clock);
    cmd_valid <= 1'b0;
    repeat (2000) begin
      @(negedge clock);
      if (done === 1'b1) begin
        got_done = 1'b1;
        break;
      end
      if (rdata_valid === 1'b1) begin
        rbuf[rcnt] = rdata;
        rcnt++;
      end
      if (wdata_valid === 1'b1 && wdata_ready === 1'b1) begin
        @(posedge clock);
        wdata_valid <= 1'b0;
        i++;
      end else if (wdata_ready === 1'b1 && i < n) begin
        @(posedge clock);
        wdata_valid <= 1'b1;
        wdata <= wbuf[i];
      end
    end
    check({7'h00, got_done}, 8'h01);
    check({6'h00, rsp}, {6'h00, er});
    if (fr != 0) check(i_dev.last_frame[7:0], fr[7:0]);
  endtask

  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    wdata_valid = 1'b0;
    wdata = 8'h00;
    cmd = '0;
    cycles = 0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    do_cmd(KIND_READ, 7'h01, 1'b1, 5'h05, 2'b00, 75);
    for (int j = 0; j < 4; j++) check(rbuf[j], 8'h23);
    check(rbuf[4], 8'h00);
    check(rcnt[7:0], 8'h05);
    wbuf = '{8'h00, 8'h51, 8'hA2, 8'hF4};
    do_cmd(KIND_WRITE, 7'h01, 1'b1, 5'h04, 2'b00, 56);
    do_cmd(KIND_READ, 7'h01, 1'b1, 5'h04, 2'b00, 66);
    for (int j = 0; j < 4; j++) check(rbuf[j], wbuf[j]);
    wbuf[0] = 8'h05;
    wbuf[1] = 8'h0A;
    do_cmd(KIND_WRITE, 7'h06, 1'b0, 5'h02, 2'b00, 38);
    do_cmd(KIND_READ, 7'h06, 1'b1, 5'h02, 2'b00, 48);
    check(rbuf[0], 8'h0A);
    check(rbuf[1], 8'h00);
    wbuf[0] = 8'h0F;
    do_cmd(KIND_WRITE, 7'h11, 1'b0, 5'h01, 2'b00, 29);
    wbuf[0] = 8'hF0;
    do_cmd(KIND_WRITE, 7'h05, 1'b0, 5'h01, 2'b00, 29);
    do_cmd(KIND_BROADCAST, 7'h11, 1'b0, 5'h01, 2'b00, 20);
    do_cmd(KIND_READ, 7'h05, 1'b0, 5'h01, 2'b00, 39);
    check(rbuf[0], 8'hFF);
    do_cmd(KIND_BROADCAST, 7'h06, 1'b0, 5'h01, 2'b00, 20);
    do_cmd(KIND_READ, 7'h05, 1'b0, 5'h01, 2'b00, 39);
    check(rbuf[0], 8'hFA);
    for (int v = 5; v < 8; v++) begin
      wbuf[0] = 8'h50 | 8'(v);
      do_cmd(KIND_WRITE, 7'h02, 1'b0, 5'h01, 2'b10, 0);
    end
    do_cmd(KIND_READ, 7'h02, 1'b0, 5'h01, 2'b00, 39);
    check(rbuf[0], 8'h51);
    check({7'h00, i_dev.bad_slew}, 8'h00);
    do_cmd(KIND_WRITE, 7'h01, 1'b0, 5'h00, 2'b10, 0);
    do_cmd(KIND_WRITE, 7'h01, 1'b0, 5'h01, 2'b10, 0, 3'h7);
    do_cmd(KIND_BROADCAST, 7'h05, 1'b0, 5'h01, 2'b10, 0);
    do_cmd(cmd_kind_t'(2'h3), 7'h01, 1'b0, 5'h01, 2'b10, 0);
    do_cmd(KIND_WRITE, 7'h01, 1'b0, 5'h01, 2'b11, 0, 3'h3);
    final_report();
  end
endmodule
